//--- verilog/sar_params.svh
// constants of the receiver auxiliary output router: register offsets, field positions, reset values
// assumes a 16-bit control-port address space and 16-bit register words
// Notes on behaviour
// RL1: two-bit enable mode, reset 01: 00 always off, 01 always on, 10 off after reset.
// RL2: in mode 10 outputs switch on with hot enable, off when lock drops.
// RL3: enable mode only gates the stream while pin routing is active.
// RL4: read-only lock status in bit 0: 0 no stream, 1 locked.
// RL5: writable hot enable bit 0 restarts outputs in mode 10.
// RL6: hot enable self-clears on lock loss; software sets it again after recovery.
// RL7: read-only bit 0 shows whether auxiliary outputs are enabled.
// RL8: policy 0: lock loss stops frame sync pulses until lock returns.
// RL9: policy 1: frame sync keeps running, receiver data held at zero while unlocked.
// RL10: software should choose ignore-loss-of-lock only when audio recovery is needed.
// RL11: routing bits: 0 group one, 1 group two, 2 I2S/TDM; reset zero.
// RL12: eight of twelve pins in two groups: serial audio group, auxiliary group.
// RL13: TDM puts audio in slots 0 and 4, auxiliary bits in slot 1.
// RL14: slot 1 uses bits 31..25 only; 24..0 are zero.
// RL15: block start flag high for first 16 samples of each block.
// RL16: auxiliary bits stream with the audio samples they belong to.
// RL17: I2S pins: 9..11 data, bit clock, frame clock; 4..8 auxiliary group.
// RL18: unclaimed pins keep ordinary function; groups switch independently.
// RL19: undefined enable mode 11 keeps outputs off.
// RL20: reserved register bits read zero, writes to them ignored.
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

`define SAR_ADDR_ENABLE_MODE   16'he0c8
`define SAR_ADDR_LOCK_STATUS   16'he0c9
`define SAR_ADDR_HOT_RESTART   16'he0ca
`define SAR_ADDR_ACTIVE_STATUS 16'he0cb
`define SAR_ADDR_LOSS_POLICY   16'he0cc
`define SAR_ADDR_PIN_ROUTING   16'he241

`define SAR_RST_ENABLE_MODE    2'h1
`define SAR_RST_HOT_RESTART    1'h0
`define SAR_RST_LOSS_POLICY    1'h0
`define SAR_RST_PIN_ROUTING    3'h0

`define SAR_BIT_GROUP1         0
`define SAR_BIT_GROUP2         1
`define SAR_BIT_TDM            2

`define SAR_PIN_VALIDITY       4
`define SAR_PIN_USER           5
`define SAR_PIN_CHAN_STATUS    6
`define SAR_PIN_BLOCK_START    7
`define SAR_PIN_VFRAME_CLK     8
`define SAR_PIN_SERIAL_OUT     9
`define SAR_PIN_BIT_CLK        10
`define SAR_PIN_FRAME_CLK      11

`define SAR_I2S_LAST_BIT       8'h3f
`define SAR_TDM_LAST_BIT       8'hff
`define SAR_SLOT_LEFT          3'h0
`define SAR_SLOT_AUX           3'h1
`define SAR_SLOT_RIGHT         3'h4
`define SAR_BLOCK_START_LEN    5'h10

`endif

//--- verilog/sar_pkg.sv
// types of the receiver auxiliary output router
// assumes sar_params.svh supplies the numbers
`default_nettype none
package sar_pkg;
   typedef enum logic [1:0] {
      SAR_MODE_OFF   = 2'h0,
      SAR_MODE_ON    = 2'h1,
      SAR_MODE_HOT   = 2'h2,
      SAR_MODE_UNDEF = 2'h3
   } sar_en_mode_t;

   typedef enum logic [1:0] {
      SAR_AUX_OFF = 2'b01,
      SAR_AUX_ON  = 2'b10
   } sar_aux_state_t;
endpackage
`default_nettype wire

//--- verilog/sar_sync2.sv
// two-flop level synchroniser, W bits wide
// assumes each bit is a quasi-static level or a gray-safe signal
`timescale 1ns/1ps
`default_nettype none
module sar_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- verilog/sar_router.sv
// receiver auxiliary output router: control-port registers on clk, serial pin engine on rx_clk
// assumes the receiver logic, its lock and sample strobe, all run on rx_clk
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_router (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] cp_addr,
   input  wire logic        cp_wr,
   input  wire logic        cp_rd,
   input  wire logic [15:0] cp_wdata,
   output logic      [15:0] cp_rdata_q,
   output logic             cp_rvalid_q,
   input  wire logic [11:0] gpio_out,
   input  wire logic [11:0] gpio_oe_n,
   input  wire logic        rx_clk,
   input  wire logic        rx_lock,
   input  wire logic        rx_sample_stb,
   input  wire logic [23:0] rx_left,
   input  wire logic [23:0] rx_right,
   input  wire logic        rx_valid_l,
   input  wire logic        rx_valid_r,
   input  wire logic        rx_user_l,
   input  wire logic        rx_user_r,
   input  wire logic        rx_cs_l,
   input  wire logic        rx_cs_r,
   input  wire logic        rx_block_start,
   input  wire logic        rx_vframe_clk,
   output logic      [23:0] src_left_q,
   output logic      [23:0] src_right_q,
   output logic             src_frame_sync_q,
   output logic      [11:0] mp_out_q,
   output logic      [11:0] mp_oe_n_q
);
   // core-clock side
   sar_pkg::sar_en_mode_t   mode_q;
   sar_pkg::sar_aux_state_t aux_state_q;
   logic                    hot_q;
   logic                    policy_q;
   logic [2:0]              route_q;
   logic                    lock_s;
   logic                    aux_on;

   sar_sync2 #(.W(1)) u_lock_sync (
      .clk (clk),
      .rst (rst),
      .d   (rx_lock),
      .q   (lock_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= sar_pkg::sar_en_mode_t'(`SAR_RST_ENABLE_MODE); // RL1
      end else if (cp_wr && cp_addr == `SAR_ADDR_ENABLE_MODE) begin
         mode_q <= sar_pkg::sar_en_mode_t'(cp_wdata[1:0]); // RL20
      end
   end

   // lock loss wins over a simultaneous write of the hot enable bit
   always_ff @(posedge clk) begin
      if (rst) begin
         hot_q <= `SAR_RST_HOT_RESTART;
      end else if (!lock_s) begin
         hot_q <= 1'b0; // RL6
      end else if (cp_wr && cp_addr == `SAR_ADDR_HOT_RESTART) begin
         hot_q <= cp_wdata[0]; // RL5
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         policy_q <= `SAR_RST_LOSS_POLICY;
         route_q  <= `SAR_RST_PIN_ROUTING; // RL11
      end else if (cp_wr) begin
         if (cp_addr == `SAR_ADDR_LOSS_POLICY) begin
            policy_q <= cp_wdata[0];
         end
         if (cp_addr == `SAR_ADDR_PIN_ROUTING) begin
            route_q <= cp_wdata[2:0]; // RL11
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aux_state_q <= sar_pkg::SAR_AUX_OFF;
      end else begin
         case (mode_q)
            sar_pkg::SAR_MODE_ON: begin
               aux_state_q <= sar_pkg::SAR_AUX_ON; // RL1
            end
            sar_pkg::SAR_MODE_HOT: begin
               case (aux_state_q)
                  sar_pkg::SAR_AUX_OFF: begin
                     if (hot_q && lock_s) begin
                        aux_state_q <= sar_pkg::SAR_AUX_ON; // RL2
                     end
                  end
                  sar_pkg::SAR_AUX_ON: begin
                     if (!lock_s) begin
                        aux_state_q <= sar_pkg::SAR_AUX_OFF; // RL2
                     end
                  end
                  default: begin
                     aux_state_q <= sar_pkg::SAR_AUX_OFF;
                  end
               endcase
            end
            default: begin
               aux_state_q <= sar_pkg::SAR_AUX_OFF; // RL19
            end
         endcase
      end
   end

   assign aux_on = (aux_state_q == sar_pkg::SAR_AUX_ON);

   always_ff @(posedge clk) begin
      if (rst) begin
         cp_rdata_q  <= 16'h0000;
         cp_rvalid_q <= 1'b0;
      end else begin
         cp_rvalid_q <= cp_rd;
         cp_rdata_q  <= 16'h0000; // RL20
         if (cp_rd) begin
            case (cp_addr)
               `SAR_ADDR_ENABLE_MODE:   cp_rdata_q <= {14'h0000, mode_q};
               `SAR_ADDR_LOCK_STATUS:   cp_rdata_q <= {15'h0000, lock_s}; // RL4
               `SAR_ADDR_HOT_RESTART:   cp_rdata_q <= {15'h0000, hot_q};
               `SAR_ADDR_ACTIVE_STATUS: cp_rdata_q <= {15'h0000, aux_on}; // RL7
               `SAR_ADDR_LOSS_POLICY:   cp_rdata_q <= {15'h0000, policy_q};
               `SAR_ADDR_PIN_ROUTING:   cp_rdata_q <= {13'h0000, route_q};
               default:                 cp_rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   a_mode_off_holds: assert property (@(posedge clk) disable iff (rst)
      (mode_q == sar_pkg::SAR_MODE_OFF || mode_q == sar_pkg::SAR_MODE_UNDEF) |=> !aux_on) // RL19
      else $error("aux outputs on in an off mode");
   a_mode_on_forces: assert property (@(posedge clk) disable iff (rst)
      mode_q == sar_pkg::SAR_MODE_ON |=> aux_on) // RL1
      else $error("aux outputs not on in always-on mode");
   a_hot_turns_on: assert property (@(posedge clk) disable iff (rst)
      (mode_q == sar_pkg::SAR_MODE_HOT && hot_q && lock_s && $stable(mode_q)) |=> aux_on) // RL2
      else $error("hot enable did not start aux outputs");
   a_lock_drop_off: assert property (@(posedge clk) disable iff (rst)
      (mode_q == sar_pkg::SAR_MODE_HOT && !lock_s) |=> !aux_on && !hot_q) // RL6
      else $error("lock loss left aux outputs or hot enable on");
   a_lock_readback: assert property (@(posedge clk) disable iff (rst)
      (cp_rd && cp_addr == `SAR_ADDR_LOCK_STATUS) |=> cp_rdata_q == {15'h0000, $past(lock_s)}) // RL4
      else $error("lock status readback wrong");
   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      cp_rvalid_q |-> cp_rdata_q[15:3] == 13'h0000) // RL20
      else $error("reserved bits read nonzero");

   // link-clock side
   logic       rx_rst;
   logic       aux_s;
   logic [3:0] cfg_s;
   logic [23:0] gpio_s;
   logic       g1_s;
   logic       g2_s;
   logic       tdm_s;
   logic       pol_s;
   logic       run;

   sar_sync2 #(.W(1)) u_rst_sync (
      .clk (rx_clk),
      .rst (1'b0),
      .d   (rst),
      .q   (rx_rst)
   );
   sar_sync2 #(.W(1)) u_aux_sync (
      .clk (rx_clk),
      .rst (rx_rst),
      .d   (aux_on),
      .q   (aux_s)
   );
   sar_sync2 #(.W(4)) u_cfg_sync (
      .clk (rx_clk),
      .rst (rx_rst),
      .d   ({policy_q, route_q}),
      .q   (cfg_s)
   );
   sar_sync2 #(.W(24)) u_gpio_sync (
      .clk (rx_clk),
      .rst (rx_rst),
      .d   ({gpio_oe_n, gpio_out}),
      .q   (gpio_s)
   );

   assign g1_s  = cfg_s[`SAR_BIT_GROUP1];
   assign g2_s  = cfg_s[`SAR_BIT_GROUP2];
   assign tdm_s = cfg_s[`SAR_BIT_TDM];
   assign pol_s = cfg_s[3];
   assign run   = rx_lock || pol_s; // RL8

   // sample hold, with the auxiliary bits latched on the same strobe
   logic [23:0] hold_l_q;
   logic [23:0] hold_r_q;
   logic [6:0]  hold_aux_q;
   logic [4:0]  bs_cnt_q;
   logic        bs_flag;

   assign bs_flag = rx_block_start || (bs_cnt_q != 5'h00);

   always_ff @(posedge rx_clk) begin
      if (rx_rst) begin
         bs_cnt_q <= 5'h00;
      end else if (rx_sample_stb) begin
         if (rx_block_start) begin
            // the strobe carrying the block start is the first of the flagged samples
            bs_cnt_q <= `SAR_BLOCK_START_LEN - 5'h01; // RL15
         end else if (bs_cnt_q != 5'h00) begin
            bs_cnt_q <= bs_cnt_q - 5'h01; // RL15
         end
      end
   end

   always_ff @(posedge rx_clk) begin
      if (rx_rst) begin
         hold_l_q   <= 24'h000000;
         hold_r_q   <= 24'h000000;
         hold_aux_q <= 7'h00;
      end else if (rx_sample_stb) begin
         hold_l_q   <= rx_lock ? rx_left : 24'h000000; // RL9
         hold_r_q   <= rx_lock ? rx_right : 24'h000000; // RL9
         hold_aux_q <= {bs_flag, rx_cs_r, rx_cs_l, rx_user_r, rx_user_l, rx_valid_r, rx_valid_l}; // RL16
      end
   end

   // frame engine: bit clock at half rx_clk, index advances on its falling edge
   logic        bclk_q;
   logic [7:0]  idx_q;
   logic [7:0]  last_idx;
   logic [7:0]  nidx;
   logic [7:0]  eff;
   logic        step;
   logic [23:0] fl_q;
   logic [23:0] fr_q;
   logic [6:0]  fa_q;
   logic [31:0] word;
   logic        ser_bit;
   logic        lrclk_d;
   logic        sd_q;
   logic        lr_q;

   assign last_idx = tdm_s ? `SAR_TDM_LAST_BIT : `SAR_I2S_LAST_BIT;
   assign step     = run && aux_s && bclk_q;
   // a format change mid-frame must not leave the index above the new frame length
   assign nidx     = (idx_q >= last_idx) ? 8'h00 : idx_q + 8'h01;
   assign eff      = (nidx - 8'h01) & last_idx;

   always_comb begin
      word = 32'h00000000;
      if (tdm_s) begin
         case (eff[7:5])
            `SAR_SLOT_LEFT:  word = {fl_q, 8'h00}; // RL13
            `SAR_SLOT_AUX:   word = {fa_q, 25'h0000000}; // RL14
            `SAR_SLOT_RIGHT: word = {fr_q, 8'h00}; // RL13
            default:         word = 32'h00000000;
         endcase
      end else begin
         word = eff[5] ? {fr_q, 8'h00} : {fl_q, 8'h00};
      end
      ser_bit = word[5'h1f - eff[4:0]];
      lrclk_d = tdm_s ? (nidx[7:5] == 3'h0) : nidx[5];
   end

   always_ff @(posedge rx_clk) begin
      if (rx_rst || !run || !aux_s) begin
         bclk_q <= 1'b0; // RL8
         idx_q  <= 8'h00;
         sd_q   <= 1'b0;
         lr_q   <= 1'b0;
      end else begin
         bclk_q <= ~bclk_q;
         if (step) begin
            idx_q <= nidx;
            sd_q  <= ser_bit;
            lr_q  <= lrclk_d;
         end
      end
   end

   always_ff @(posedge rx_clk) begin
      if (rx_rst) begin
         fl_q <= 24'h000000;
         fr_q <= 24'h000000;
         fa_q <= 7'h00;
      end else if (step && nidx == 8'h00) begin
         fl_q <= hold_l_q;
         fr_q <= hold_r_q;
         fa_q <= hold_aux_q; // RL16
      end
   end

   // receiver output toward the rate converter: frame sync stops unless running
   always_ff @(posedge rx_clk) begin
      if (rx_rst) begin
         src_frame_sync_q <= 1'b0;
         src_left_q       <= 24'h000000;
         src_right_q      <= 24'h000000;
      end else begin
         src_frame_sync_q <= run && rx_sample_stb; // RL8
         if (rx_sample_stb) begin
            src_left_q  <= rx_lock ? rx_left : 24'h000000; // RL9
            src_right_q <= rx_lock ? rx_right : 24'h000000; // RL9
         end
      end
   end

   // pin mux: a group claims its pins only when enabled, stream gated by aux state
   logic [11:0] pin_d;
   logic [11:0] oe_n_d;
   logic        chan_r;

   assign chan_r = lr_q;

   always_comb begin
      pin_d  = gpio_s[11:0]; // RL18
      oe_n_d = gpio_s[23:12];
      if (g1_s) begin
         pin_d[`SAR_PIN_SERIAL_OUT]  = aux_s && sd_q; // RL3
         pin_d[`SAR_PIN_BIT_CLK]     = aux_s && bclk_q; // RL17
         pin_d[`SAR_PIN_FRAME_CLK]   = aux_s && lr_q; // RL17
         oe_n_d[`SAR_PIN_SERIAL_OUT] = 1'b0; // RL12
         oe_n_d[`SAR_PIN_BIT_CLK]    = 1'b0;
         oe_n_d[`SAR_PIN_FRAME_CLK]  = 1'b0;
      end
      if (g2_s) begin
         pin_d[`SAR_PIN_VALIDITY]    = aux_s && (chan_r ? fa_q[1] : fa_q[0]); // RL17
         pin_d[`SAR_PIN_USER]        = aux_s && (chan_r ? fa_q[3] : fa_q[2]);
         pin_d[`SAR_PIN_CHAN_STATUS] = aux_s && (chan_r ? fa_q[5] : fa_q[4]);
         pin_d[`SAR_PIN_BLOCK_START] = aux_s && fa_q[6];
         pin_d[`SAR_PIN_VFRAME_CLK]  = aux_s && rx_vframe_clk; // RL3
         oe_n_d[8:4]                 = 5'h00; // RL12
      end
   end

   always_ff @(posedge rx_clk) begin
      if (rx_rst) begin
         mp_out_q  <= 12'h000;
         mp_oe_n_q <= 12'hfff;
      end else begin
         mp_out_q  <= pin_d;
         mp_oe_n_q <= oe_n_d; // RL18
      end
   end

   a_sync_stops: assert property (@(posedge rx_clk) disable iff (rx_rst)
      (!rx_lock && !pol_s) |=> !src_frame_sync_q && idx_q == 8'h00 && !bclk_q) // RL8
      else $error("frame sync running while unlocked in disable policy");
   a_data_zero: assert property (@(posedge rx_clk) disable iff (rx_rst)
      (!rx_lock && rx_sample_stb) |=> src_left_q == 24'h000000 && src_right_q == 24'h000000) // RL9
      else $error("receiver data nonzero while unlocked");
   a_sync_kept: assert property (@(posedge rx_clk) disable iff (rx_rst)
      (pol_s && rx_sample_stb) |=> src_frame_sync_q) // RL9
      else $error("frame sync lost in ignore policy");
   a_block_len: assert property (@(posedge rx_clk) disable iff (rx_rst)
      (rx_sample_stb && rx_block_start) |=> bs_cnt_q == 5'h0f) // RL15
      else $error("block start count wrong");
   a_group_release: assert property (@(posedge rx_clk) disable iff (rx_rst)
      (!g1_s && !g2_s) |=> mp_oe_n_q == $past(gpio_s[23:12])) // RL18
      else $error("pins claimed with both groups off");
   a_group1_claim: assert property (@(posedge rx_clk) disable iff (rx_rst)
      g1_s |=> mp_oe_n_q[11:9] == 3'h0) // RL12
      else $error("group one pins not driven");
endmodule
`default_nettype wire

//--- verilog/sar_dummy_unused.sv
`timescale 1ns/1ps

//--- verification/sar_serial_sink.sv
// passive serial audio receiver watching the multipurpose pins
// assumes data on pin 9, bit clock on pin 10, frame clock on pin 11
`timescale 1ns/1ps
`default_nettype none
module sar_serial_sink (
   input  wire logic [11:0]  mp_pin,
   input  wire logic         tdm,
   output logic      [255:0] frame_q,
   output int                frames
);
   logic [255:0] sh = 256'h0;
   logic         lr_q = 1'b0;
   logic         started = 1'b0;

   initial frames = 0;

   // a frame opens on the frame clock rise in tdm and on its fall in i2s
   always @(posedge mp_pin[10]) begin
      sh = {sh[254:0], mp_pin[9]};
      if (mp_pin[11] !== lr_q && mp_pin[11] === tdm) begin
         if (started) begin
            frame_q = sh;
            frames = frames + 1;
         end
         started = 1'b1;
      end
      lr_q = mp_pin[11];
   end
endmodule
`default_nettype wire

//--- verification/test_spdif_aux_output_router.sv
// self-checking bench of the receiver auxiliary output router
// assumes sar_router and sar_serial_sink are compiled beforehand
`timescale 1ns/1ps
`default_nettype none
module test_spdif_aux_output_router;
   logic         clk = 1'b0, rx_clk = 1'b0, rst = 1'b1;
   logic [15:0]  cp_addr = 16'h0, cp_wdata = 16'h0;
   logic         cp_wr = 1'b0, cp_rd = 1'b0;
   logic [15:0]  cp_rdata_q;
   logic         cp_rvalid_q;
   logic [11:0]  gpio_out = 12'h0, gpio_oe_n = 12'hfff;
   logic         rx_lock = 1'b0, rx_sample_stb = 1'b0, rx_block_start = 1'b0, rx_vframe_clk = 1'b0;
   logic [23:0]  rx_left = 24'h0, rx_right = 24'h0;
   logic         rx_valid_l = 1'b0, rx_valid_r = 1'b0, rx_user_l = 1'b0, rx_user_r = 1'b0;
   logic         rx_cs_l = 1'b0, rx_cs_r = 1'b0;
   logic [23:0]  src_left_q, src_right_q;
   logic         src_frame_sync_q;
   logic [11:0]  mp_out_q, mp_oe_n_q;
   logic [255:0] frm;
   int           frames, seed, n0;
   int           n_fail = 0, n_tests = 0, n_sync = 0, cyc = 0;
   logic         tdm = 1'b0, bs_req = 1'b0;
   logic [5:0]   ph = 6'h0;

   sar_router dut_u (.clk, .rst, .cp_addr, .cp_wr, .cp_rd, .cp_wdata, .cp_rdata_q, .cp_rvalid_q, .gpio_out,
      .gpio_oe_n, .rx_clk, .rx_lock, .rx_sample_stb, .rx_left, .rx_right, .rx_valid_l, .rx_valid_r, .rx_user_l,
      .rx_user_r, .rx_cs_l, .rx_cs_r, .rx_block_start, .rx_vframe_clk, .src_left_q, .src_right_q,
      .src_frame_sync_q, .mp_out_q, .mp_oe_n_q);
   sar_serial_sink sink_u (.mp_pin(mp_out_q), .tdm(tdm), .frame_q(frm), .frames(frames));

   always #2.5 clk = ~clk;
   initial begin
      #7.3;
      forever #15 rx_clk = ~rx_clk;
   end

   // one stereo sample every 64 link cycles
   always @(posedge rx_clk) begin
      ph <= ph + 6'h1;
      rx_sample_stb <= (ph == 6'h3f);
      rx_block_start <= (ph == 6'h3f) && bs_req;
      if (ph == 6'h3f) bs_req <= 1'b0;
      if (src_frame_sync_q === 1'b1) n_sync <= n_sync + 1;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      cp_addr <= a;
      cp_wdata <= d;
      cp_wr <= 1'b1;
      @(posedge clk);
      cp_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      cp_addr <= a;
      cp_rd <= 1'b1;
      @(posedge clk);
      cp_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {15'h0, e, 1'b1}, {15'h0, cp_rdata_q, cp_rvalid_q});
   endtask

   task automatic cw(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic rw(input int n);
      repeat (n) @(posedge rx_clk);
   endtask

   task automatic lrw(input logic v);
      for (int i = 0; i < 300 && mp_out_q[11] !== v; i++) @(posedge rx_clk);
      chk("frame clock", {31'h0, v}, {31'h0, mp_out_q[11]});
   endtask

   task automatic wf(input int n);
      int t;
      t = frames + n;
      for (int i = 0; i < 20000 && frames < t; i++) @(posedge clk);
      chk("frame count", 32'h1, {31'h0, frames >= t});
   endtask

   function automatic logic [31:0] aux(input logic bs);
      return {bs, rx_cs_r, rx_cs_l, rx_user_r, rx_user_l, rx_valid_r, rx_valid_l, 25'h0};
   endfunction

   function automatic logic [31:0] slot(input int w);
      case (w)
         0: return {rx_left, 8'h0};
         1: return aux(1'b0);
         4: return {rx_right, 8'h0};
         default: return 32'h0;
      endcase
   endfunction

   initial begin
      seed = $urandom(32'h00f7);
      repeat (5) @(posedge rx_clk);
      @(posedge clk);
      rst <= 1'b0;
      rx_left <= 24'($urandom);
      rx_right <= 24'($urandom);
      {rx_valid_l, rx_valid_r, rx_user_l, rx_user_r, rx_cs_l, rx_cs_r, rx_vframe_clk} <= 7'($urandom);
      gpio_out <= 12'($urandom);
      gpio_oe_n <= 12'($urandom);
      rd(16'he0c8, 16'h1);
      rd(16'he0ca, 16'h0);
      rd(16'he0cc, 16'h0);
      rd(16'he241, 16'h0);
      rd(16'he0cb, 16'h1);
      rd(16'he0c9, 16'h0);
      rd(16'he0cd, 16'h0);
      rx_lock <= 1'b1;
      cw(6);
      rd(16'he0c9, 16'h1);
      wr(16'he0c9, 16'h0);
      rd(16'he0c9, 16'h1);
      wr(16'he0c8, 16'hffff);
      rd(16'he0c8, 16'h3);
      rd(16'he0cb, 16'h0);
      wr(16'he0c8, 16'h0);
      rd(16'he0cb, 16'h0);
      wr(16'he0c8, 16'h2);
      rd(16'he0cb, 16'h0);
      wr(16'he0ca, 16'h1);
      rd(16'he0ca, 16'h1);
      rd(16'he0cb, 16'h1);
      rx_lock <= 1'b0;
      cw(6);
      rd(16'he0cb, 16'h0);
      rd(16'he0ca, 16'h0);
      wr(16'he0ca, 16'h1);
      rd(16'he0ca, 16'h0);
      rx_lock <= 1'b1;
      cw(6);
      rd(16'he0cb, 16'h0);
      wr(16'he0ca, 16'hffff);
      rd(16'he0ca, 16'h1);
      rd(16'he0cb, 16'h1);
      // frame sync with each loss policy
      rx_lock <= 1'b0;
      rw(10);
      n0 = n_sync;
      rw(300);
      chk("sync held", n0, n_sync);
      rx_lock <= 1'b1;
      rw(10);
      n0 = n_sync;
      rw(300);
      chk("sync resumed", 32'h1, {31'h0, n_sync > n0});
      chk("src left", {8'h0, rx_left}, {8'h0, src_left_q});
      wr(16'he0cc, 16'hffff);
      rd(16'he0cc, 16'h1);
      rx_lock <= 1'b0;
      rw(10);
      n0 = n_sync;
      rw(300);
      chk("sync free", 32'h1, {31'h0, n_sync > n0});
      chk("src zero", 32'h0, {8'h0, src_right_q});
      rx_lock <= 1'b1;
      wr(16'he0cc, 16'h0);
      // i2s routing
      wr(16'he0c8, 16'h1);
      wr(16'he241, 16'h1);
      wf(3);
      chk("i2s left", {rx_left, 8'h0}, frm[63:32]);
      chk("i2s right", {rx_right, 8'h0}, frm[31:0]);
      chk("pin enables", {23'h0, gpio_oe_n[8:0]}, {20'h0, mp_oe_n_q});
      chk("gpio pins", {23'h0, gpio_out[8:0]}, {23'h0, mp_out_q[8:0]});
      wr(16'he241, 16'h3);
      rw(10);
      lrw(1'b1);
      lrw(1'b0);
      rw(8);
      chk("aux left", {28'h0, rx_vframe_clk, rx_cs_l, rx_user_l, rx_valid_l},
          {28'h0, mp_out_q[8], mp_out_q[6:4]});
      chk("aux enables", 32'h0, {27'h0, mp_oe_n_q[8:4]});
      lrw(1'b1);
      rw(8);
      chk("aux right", {29'h0, rx_cs_r, rx_user_r, rx_valid_r}, {29'h0, mp_out_q[6:4]});
      wr(16'he241, 16'h2);
      rw(10);
      chk("group one off", {29'h0, gpio_oe_n[11:9]}, {29'h0, mp_oe_n_q[11:9]});
      wr(16'he241, 16'h3);
      wr(16'he0c8, 16'h0);
      rw(20);
      chk("muted pins", 32'h0, {24'h0, mp_out_q[11:4]});
      chk("muted enables", 32'h0, {24'h0, mp_oe_n_q[11:4]});
      // tdm routing and block start
      wr(16'he0c8, 16'h1);
      wr(16'he241, 16'h5);
      tdm <= 1'b1;
      wf(2);
      for (int w = 0; w < 8; w++) chk($sformatf("slot %0d", w), slot(w), frm[255-32*w -: 32]);
      bs_req <= 1'b1;
      rw(70);
      wf(2);
      chk("block start", aux(1'b1), frm[223:192]);
      wf(4);
      chk("block end", aux(1'b0), frm[223:192]);
      summarize();
   end
endmodule
`default_nettype wire
